//--- hw/otpc_defines.vh
// Register map, field positions, reset values and timing for the OTP command block
`ifndef OTPC_DEFINES_VH
`define OTPC_DEFINES_VH
`define OTPC_ADDR_GATE 8'h51
`define OTPC_ADDR_TADDR 8'h52
`define OTPC_ADDR_DATA 8'h53
`define OTPC_ADDR_CMD 8'h54
`define OTPC_ADDR_RUNSTAT 8'h56
`define OTPC_ADDR_CTRLSTAT 8'h58
`define OTPC_GATE_BIT 0
`define OTPC_CMD_PROG_BIT 0
`define OTPC_CMD_FETCH_BIT 1
`define OTPC_CMD_SEAL_BIT 3
`define OTPC_ST_WR_OK_BIT 0
`define OTPC_ST_WR_DENIED_BIT 1
`define OTPC_ST_DONE_BIT 3
`define OTPC_ST_RDY_BIT 2
`define OTPC_ST_SEAL_OK_BIT 4
`define OTPC_ST_CSUM_OK_BIT 5
`define OTPC_RUN_USED_BIT 0
`define OTPC_RUN_SEALED_BIT 1
`define OTPC_RUN_VERIFIED_BIT 2
`define OTPC_RESET_BYTE 8'h00
`define OTPC_PROG_TIME_NS 1000
`define OTPC_CLK_PERIOD_NS 20
`define OTPC_PROG_CYCLES ((`OTPC_PROG_TIME_NS + `OTPC_CLK_PERIOD_NS - 1) / `OTPC_CLK_PERIOD_NS)
`define OTPC_FETCH_CYCLES 2
`define OTPC_REGION_LAST 8'h7f
`endif

//--- hw/otpc_array.v
// One-time-programmable byte array model with bit-accumulating writes
`timescale 1ns/1ps
module otpc_array (
	input wire clk,
	input wire resetn,
	input wire prog_en,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	output reg [7:0] rdata
);
	reg [7:0] mem [0:255];
	integer i;

	// Writes only take fuses from 0 to 1; reset clears the whole array
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < 256; i = i + 1) begin
				mem[i] <= 8'h00;
			end
			rdata <= 8'h00;
		end else begin
			if (prog_en) begin
				mem[addr] <= mem[addr] | wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule

//--- hw/otpc_top.v
// OTP command interface: holding registers, command sequencer, status
//
// Notes on behaviour
// - Commands accepted only while gate bit set
// - Address holding register selects memory location
// - Data register supplies write byte, receives read
// - Program request bit self-clears after programming
// - Fetch request bit self-clears when data ready
// - Seal request locks region, then self-clears
// - Request bits auto-clear; all reset zero
// - Control status reports write, seal, checksum outcomes
// - Run status reports used, sealed, verified
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "otpc_defines.vh"
module otpc_top (
	input wire clk,
	input wire resetn,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	output reg busy_q
);
	localparam S_IDLE = 2'd0;
	localparam S_PROG = 2'd1;
	localparam S_FETCH = 2'd2;
	localparam S_SEAL = 2'd3;
	localparam integer PROG_CYC = `OTPC_PROG_CYCLES;
	localparam integer FETCH_CYC = `OTPC_FETCH_CYCLES;
	localparam [7:0] PROG_CNT = PROG_CYC[7:0];
	localparam [7:0] FETCH_CNT = FETCH_CYC[7:0];

	reg [1:0] state_q;
	reg [7:0] cnt_q;
	reg gate_q;
	reg [7:0] taddr_q;
	reg [7:0] data_q;
	reg [7:0] cmd_q;
	reg wr_ok_q;
	reg wr_denied_q;
	reg seal_ok_q;
	reg csum_ok_q;
	reg done_q;
	reg region_used_q;
	reg region_sealed_q;
	reg region_verified_q;
	reg prog_en;
	wire [7:0] arr_rdata;
	wire in_region;
	wire [7:0] ctrlstat;
	wire [7:0] runstat;
	reg [7:0] rd_mux;
	wire idle;
	reg [1:0] state_d;
	reg [7:0] cnt_d;
	reg [7:0] cmd_d;
	wire cmd_wr;
	wire start;
	wire last_cnt;
	wire prog_blocked;
	wire fin;

	assign idle = (state_q == S_IDLE);
	assign in_region = (taddr_q <= `OTPC_REGION_LAST);

	otpc_array u_array (
		.clk(clk),
		.resetn(resetn),
		.prog_en(prog_en),
		.addr(taddr_q),
		.wdata(data_q),
		.rdata(arr_rdata)
	);

	// ----------------------------------------------------------------
	// Status assembly
	// ----------------------------------------------------------------
	assign ctrlstat = {2'b00, csum_ok_q, seal_ok_q, done_q, idle,
		wr_denied_q, wr_ok_q};
	assign runstat = {5'b00000, region_verified_q, region_sealed_q,
		region_used_q};

	always @* begin
		case (reg_addr)
		`OTPC_ADDR_GATE: rd_mux = {7'b0000000, gate_q};
		`OTPC_ADDR_TADDR: rd_mux = taddr_q;
		`OTPC_ADDR_DATA: rd_mux = data_q;
		`OTPC_ADDR_CMD: rd_mux = cmd_q;
		`OTPC_ADDR_RUNSTAT: rd_mux = runstat;
		`OTPC_ADDR_CTRLSTAT: rd_mux = ctrlstat;
		default: rd_mux = 8'h00;
		endcase
	end

	always @* begin
		prog_en = (state_q == S_PROG) && last_cnt && !prog_blocked;
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	assign cmd_wr = reg_wr && (reg_addr == `OTPC_ADDR_CMD);
	assign start = cmd_wr && gate_q && idle;
	assign last_cnt = (cnt_q == 8'h01);
	assign prog_blocked = region_sealed_q && in_region;
	assign fin = (state_q == S_SEAL) ||
		((state_q == S_PROG || state_q == S_FETCH) && last_cnt);

	// ----------------------------------------------------------------
	// Sequencer next state
	// ----------------------------------------------------------------
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		cmd_d = cmd_q;
		case (state_q)
		S_IDLE: begin
			// Lowest request bit wins if several set
			if (start) begin
				if (reg_wdata[`OTPC_CMD_PROG_BIT]) begin
					state_d = S_PROG;
					cnt_d = PROG_CNT;
					cmd_d = 8'h01 << `OTPC_CMD_PROG_BIT;
				end else if (reg_wdata[`OTPC_CMD_FETCH_BIT]) begin
					state_d = S_FETCH;
					cnt_d = FETCH_CNT;
					cmd_d = 8'h01 << `OTPC_CMD_FETCH_BIT;
				end else if (reg_wdata[`OTPC_CMD_SEAL_BIT]) begin
					state_d = S_SEAL;
					cnt_d = 8'h01;
					cmd_d = 8'h01 << `OTPC_CMD_SEAL_BIT;
				end
			end
		end
		S_PROG, S_FETCH: begin
			cnt_d = cnt_q - 8'h01;
			if (last_cnt) begin
				state_d = S_IDLE;
				cmd_d = `OTPC_RESET_BYTE;
			end
		end
		S_SEAL: begin
			state_d = S_IDLE;
			cnt_d = 8'h00;
			cmd_d = `OTPC_RESET_BYTE;
		end
		default: begin
			state_d = S_IDLE;
			cnt_d = 8'h00;
			cmd_d = `OTPC_RESET_BYTE;
		end
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer registers
	// ----------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= S_IDLE;
			cnt_q <= 8'h00;
			cmd_q <= `OTPC_RESET_BYTE;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cmd_q <= cmd_d;
		end
	end

	// ----------------------------------------------------------------
	// Holding registers
	// ----------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gate_q <= 1'b0;
			taddr_q <= `OTPC_RESET_BYTE;
			data_q <= `OTPC_RESET_BYTE;
		end else begin
			if (reg_wr && reg_addr == `OTPC_ADDR_GATE)
				gate_q <= reg_wdata[`OTPC_GATE_BIT];
			if (reg_wr && reg_addr == `OTPC_ADDR_TADDR)
				taddr_q <= reg_wdata;
			// Fetched byte takes priority over a software write
			if (state_q == S_FETCH && last_cnt)
				data_q <= arr_rdata;
			else if (reg_wr && reg_addr == `OTPC_ADDR_DATA)
				data_q <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Outcome and run status flags
	// ----------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ok_q <= 1'b0;
			wr_denied_q <= 1'b0;
			seal_ok_q <= 1'b0;
			csum_ok_q <= 1'b0;
			done_q <= 1'b0;
			region_used_q <= 1'b0;
			region_sealed_q <= 1'b0;
			region_verified_q <= 1'b0;
		end else begin
			if (start)
				done_q <= 1'b0;
			else if (fin)
				done_q <= 1'b1;
			if (state_q == S_PROG && last_cnt) begin
				wr_ok_q <= !prog_blocked;
				wr_denied_q <= prog_blocked;
				if (!prog_blocked && in_region)
					region_used_q <= 1'b1;
			end
			if (state_q == S_SEAL) begin
				region_sealed_q <= 1'b1;
				seal_ok_q <= 1'b1;
				region_verified_q <= 1'b1;
				csum_ok_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read port and busy output
	// ----------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_q <= `OTPC_RESET_BYTE;
			busy_q <= 1'b0;
		end else begin
			// Read data stands in the cycle after each read strobe; zero otherwise
			reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
			busy_q <= !idle;
		end
	end
endmodule

//--- verif/otpc_checker.sv
// Port-level assertions for the OTP command block
`timescale 1ns/1ps
module otpc_checker (
	input wire clk,
	input wire resetn,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_q,
	input wire busy_q
);
	reg [7:0] gate_q;
	reg [7:0] tadr_q;
	wire cw = reg_wr && reg_addr == 8'h54;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gate_q <= 8'h00;
			tadr_q <= 8'h00;
		end else if (reg_wr && reg_addr == 8'h51) begin
			gate_q <= reg_wdata;
		end else if (reg_wr && reg_addr == 8'h52) begin
			tadr_q <= reg_wdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_rz; !reg_rd |=> reg_rdata_q == 8'h00; endproperty
	property p_on; cw && gate_q[0] && !busy_q &&
		(reg_wdata[0] || reg_wdata[1] || reg_wdata[3]) |-> ##[1:3] busy_q;
	endproperty
	property p_off; cw && !gate_q[0] && !busy_q |=> !busy_q [*3]; endproperty
	property p_bnd; $rose(busy_q) |-> ##[1:60] !busy_q; endproperty
	property p_unm; reg_rd && reg_addr == 8'h40 |=> reg_rdata_q == 0;
	endproperty
	property p_gate; reg_rd && reg_addr == 8'h51 |=>
		reg_rdata_q == {7'h00, $past(gate_q[0])};
	endproperty
	property p_adr; reg_rd && reg_addr == 8'h52 |=> reg_rdata_q == $past(tadr_q);
	endproperty
	property p_res; reg_rd && reg_addr == 8'h56 |=> reg_rdata_q[7:3] == 0;
	endproperty
	property p_cz; reg_rd && reg_addr == 8'h54 && !busy_q && !$past(reg_wr) &&
		!$past(reg_wr, 2) |=> reg_rdata_q == 8'h00; endproperty
	a_rz: assert property (p_rz) else $error("idle read data");
	a_on: assert property (p_on) else $error("command not started");
	a_off: assert property (p_off) else $error("gated command ran");
	a_bnd: assert property (p_bnd) else $error("busy too long");
	a_unm: assert property (p_unm) else $error("unmapped read");
	a_gate: assert property (p_gate) else $error("gate readback");
	a_adr: assert property (p_adr) else $error("address readback");
	a_res: assert property (p_res) else $error("run status spare");
	a_cz: assert property (p_cz) else $error("request not cleared");
	c_on: cover property (cw && gate_q[0] ##[1:3] busy_q);
	c_off: cover property (cw && !gate_q[0]);
	c_unm: cover property (reg_rd && reg_addr == 8'h40);
endmodule
bind otpc_top otpc_checker u_chk (.clk(clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .busy_q(busy_q));

//--- verif/tb_top.sv
// Self-checking bench for the OTP command block
`timescale 1ns/1ps
module tb_top;
	reg clk = 1'b0;
	reg resetn = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	wire [7:0] reg_rdata_q;
	wire busy_q;
	integer errors = 0;
	integer checked = 0;
	integer n;
	reg [7:0] d;
	otpc_top uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .busy_q(busy_q));
	initial forever #10 clk = ~clk;
	task conclude;
		begin
			$display("checked %0d errors %0d", checked, errors);
			if (errors == 0 && checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input [7:0] g, input [7:0] e);
		begin
			checked = checked + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("mismatch at %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		begin
			@(posedge clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= v;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rc(input [7:0] a, input [7:0] m, input [7:0] e);
		begin
			@(posedge clk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1 d = reg_rdata_q;
			if (m != 0) chk(d & m, e);
		end
	endtask
	// Poll the command register until idle
	task wt;
		begin
			n = 0;
			d = 8'hff;
			while (d !== 8'h00 && n < 100) begin
				rc(8'h54, 8'h00, 8'h00);
				n = n + 1;
			end
			chk(d, 8'h00);
			chk({7'h00, busy_q}, 8'h00);
			if (d !== 8'h00) conclude;
		end
	endtask
	task t_rst;
		begin
			for (n = 0; n < 6; n = n + 1)
				rc(8'h51 + n, 8'hff, 8'h00);
			rc(8'h40, 8'hff, 8'h00);
			rc(8'h58, 8'hff, 8'h04);
			$display("reset test done");
		end
	endtask
	task t_off;
		begin
			wr(8'h52, 8'h05);
			wr(8'h53, 8'ha5);
			wr(8'h54, 8'h01);
			rc(8'h54, 8'hff, 8'h00);
			rc(8'h53, 8'hff, 8'ha5);
			rc(8'h52, 8'hff, 8'h05);
			$display("gate test done");
		end
	endtask
	task t_cmd;
		begin
			wr(8'h51, 8'h01);
			wr(8'h54, 8'h01);
			@(posedge clk);
			#1 chk({7'h00, busy_q}, 8'h01);
			wt;
			rc(8'h58, 8'h03, 8'h01);
			rc(8'h56, 8'h01, 8'h01);
			wr(8'h53, 8'h00);
			wr(8'h54, 8'h02);
			wt;
			rc(8'h53, 8'hff, 8'ha5);
			wr(8'h54, 8'h08);
			wt;
			rc(8'h56, 8'hff, 8'h07);
			rc(8'h58, 8'h30, 8'h30);
			wr(8'h54, 8'h01);
			wt;
			rc(8'h58, 8'h03, 8'h02);
			$display("command test done");
		end
	endtask
	// Outside the sealed region, several request bits at once
	task t_out;
		begin
			wr(8'h52, 8'h85);
			wr(8'h53, 8'h3c);
			wr(8'h54, 8'h01);
			wt;
			rc(8'h58, 8'hff, 8'h3d);
			wr(8'h53, 8'h00);
			wr(8'h54, 8'h0b);
			rc(8'h54, 8'hff, 8'h01);
			wt;
			wr(8'h54, 8'h02);
			wt;
			rc(8'h53, 8'hff, 8'h3c);
			rc(8'h56, 8'hff, 8'h07);
			$display("region test done");
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_rst;
		t_off;
		t_cmd;
		t_out;
		conclude;
	end
endmodule
